// File: core/gpio_line_defs.svh
`ifndef GPIO_LINE_DEFS_SVH
`define GPIO_LINE_DEFS_SVH

// register byte offsets on the apb bus
`define GP_OFS_PICK      8'h00
`define GP_OFS_LINE      8'h04
`define GP_OFS_GLITCH    8'h08
`define GP_OFS_PULSE_CNT 8'h0c
`define GP_OFS_HIGH      8'h10
`define GP_OFS_LOW       8'h14
`define GP_OFS_DELAY     8'h18
`define GP_OFS_PATTERN   8'h1c
`define GP_OFS_LEVEL     8'h20
`define GP_OFS_ALL       8'h24
`define GP_OFS_GLOBAL    8'h28

// field layout
`define GP_LINE_W        7
`define GP_GLB_AUX       0
`define GP_GLB_TRIG      1
`define GP_GLB_FROM_TRIG 2
`define GP_GLB_WIN_LSB   3
`define GP_GLB_WIN_MSB   4

// reset values: line 1 is output only, so it starts as output
`define GP_RST_FN        8'h04
`define GP_RST_PATTERN   8'hff
// allowed function codes, four bits per line, line 0 lowest
`define GP_FN_ALLOWED    16'hffa5

// timing
`define GP_CLK_PERIOD_NS 5
`define GP_US_NS         1000
`define GP_US_CYCLES     (`GP_US_NS / `GP_CLK_PERIOD_NS)
`define GP_REJECT_TICKS  16'h0010

// exposure window kinds
`define GP_WIN_LINE1     2'h0
`define GP_WIN_ANY       2'h1
`define GP_WIN_ALL       2'h2

`endif

// File: core/gpio_line_pkg.sv
package gpio_line_pkg;

    typedef enum logic [1:0] {
        FN_INPUT   = 2'h0,
        FN_OUTPUT  = 2'h1,
        FN_TRIGGER = 2'h2,
        FN_STROBE  = 2'h3
    } line_fn_t;

    typedef enum logic [1:0] {
        SRC_EXPOSURE = 2'h0,
        SRC_TRIGGER  = 2'h1,
        SRC_USER     = 2'h2,
        SRC_USER_ALT = 2'h3
    } out_choice_t;

    typedef struct packed {
        logic        software_drive_level;
        logic        flash_pulse_on;
        logic        polarity_flip;
        out_choice_t output_signal_choice;
        line_fn_t    line_function;
    } line_cfg_t;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_DELAY = 5'h02,
        ST_HIGH  = 5'h04,
        ST_LOW   = 5'h08,
        ST_EXPO  = 5'h10
    } strobe_state_t;

    typedef struct packed {
        logic [2:0]  sync;
        logic        level_sync;
        logic        clean;
        logic [15:0] cnt;
    } filter_state_t;

endpackage

// File: core/line_filter.sv
`timescale 1ns/10ps
`default_nettype none
`include "gpio_line_defs.svh"

module line_filter
    import gpio_line_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        pin_async,
    input  wire logic        pix_tick,
    input  wire logic        us_tick,
    input  wire logic        use_us,
    input  wire logic [15:0] glitch_us,
    output logic             level_sync,
    output logic             level_clean
);

    filter_state_t s_reg;
    filter_state_t s_next;
    logic [15:0]   limit;
    logic          tick;

    // three-stage sync; a change counts once stages two and three agree
    always_comb begin
        s_next = s_reg;
        limit  = use_us ? glitch_us : `GP_REJECT_TICKS;
        tick   = use_us ? us_tick : pix_tick;
        s_next.sync = {s_reg.sync[1:0], pin_async};
        if (s_reg.sync[1] == s_reg.sync[2]) begin
            s_next.level_sync = s_reg.sync[2];
        end
        // pulses shorter than the limit never reach the clean level
        if (s_reg.level_sync == s_reg.clean) begin
            s_next.cnt = 16'h0000;
        end else if (tick) begin
            if (s_reg.cnt + 16'h0001 >= limit) begin
                s_next.clean = s_reg.level_sync;
                s_next.cnt   = 16'h0000;
            end else begin
                s_next.cnt = s_reg.cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign level_sync  = s_reg.level_sync;
    assign level_clean = s_reg.clean;

endmodule

`default_nettype wire

// File: core/camera_gpio_line_control.sv
// Contract
// - line function input makes the line a receiver of trigger signals.
// - line function output drives the line toward outside circuitry.
// - trigger function plus trigger mode: an edge on the line grabs an image.
// - enabling trigger mode suspends continuous streaming.
// - strobe function pulses after a delay from integration start or trigger.
// - strobe fires only on frames selected by a per-line pattern.
// - line_pick selects one of lines 0 to 3 for per-line settings.
// - four functions offered; the allowed set depends on the line.
// - output lines send exposure-active or trigger-active as chosen.
// - polarity_flip inverts the selected line's input or output signal.
// - pin_level_read returns the selected line level, one meaning high.
// - all_pins_level_read returns every line level in one bitfield.
// - each line holds a glitch filter time in microseconds.
// - flash_pulse_length gives pulse count with programmable high and low.
// - exposure window kind: 00 line 1, 01 any pixel, 10 all pixels.
// - any and all pixel kinds follow the imaging core's window inputs.
// - aux_supply_on switches the auxiliary 3.3 V output.
// - without the debouncer, pulses under 16 pixel ticks are rejected.
// - the debouncer only acts on lines in input function.
// - a pulse count of zero gives one pulse as long as exposure.
`timescale 1ns/10ps
`default_nettype none
`include "gpio_line_defs.svh"

module camera_gpio_line_control
    import gpio_line_pkg::*;
#(
    parameter int LINES   = 4,
    parameter int PIX_DIV = 4
)
(
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic [LINES-1:0] line_in,
    output logic      [LINES-1:0] line_out,
    output logic      [LINES-1:0] line_oe,
    input  wire logic             integration_start,
    input  wire logic             exposure_line1,
    input  wire logic             exposure_any,
    input  wire logic             exposure_all,
    output logic                  grab_trigger,
    output logic                  stream_suspend,
    output logic                  aux_supply_on
);

    typedef struct packed {
        logic [1:0]                 line_pick;
        line_cfg_t [LINES-1:0]      cfg;
        logic [LINES-1:0][15:0]     glitch_filter_us;
        logic [LINES-1:0][7:0]      pattern;
        logic [7:0]                 flash_pulse_length;
        logic [15:0]                high_us;
        logic [15:0]                low_us;
        logic [15:0]                delay_us;
        logic                       aux;
        logic                       trig_mode;
        logic                       from_trig;
        logic [1:0]                 exposure_window_kind;
        logic [7:0]                 pix_cnt;
        logic [7:0]                 us_cnt;
        logic                       pix_tick;
        logic                       us_tick;
        logic [LINES-1:0]           prev_in;
        logic                       win_prev;
        logic                       grab;
        logic                       trig_active;
        strobe_state_t              st;
        logic [15:0]                st_cnt;
        logic [7:0]                 pulses_left;
        logic [2:0]                 frame_idx;
        logic [LINES-1:0]           fire_mask;
        logic                       strobe_level;
        logic [LINES-1:0]           out;
        logic [LINES-1:0]           oe;
        logic [31:0]                rdata;
        logic                       ready;
        logic                       err;
    } state_t;

    localparam logic [15:0] FN_ALLOWED = `GP_FN_ALLOWED;
    localparam logic [7:0]  RST_FN     = `GP_RST_FN;
    localparam logic [7:0]  PIX_LAST   = 8'(PIX_DIV - 1);
    localparam logic [7:0]  US_LAST    = 8'(`GP_US_CYCLES - 1);

    state_t           s_reg;
    state_t           s_next;
    logic [LINES-1:0] level_sync;
    logic [LINES-1:0] level_clean;
    logic [LINES-1:0] use_us;

    // per-line input sync and glitch filter
    genvar g;
    generate
        for (g = 0; g < LINES; g++) begin : gen_line
            assign use_us[g] = (s_reg.cfg[g].line_function == FN_INPUT) &&
                               (s_reg.glitch_filter_us[g] != 16'h0000);
            line_filter u_filter (
                .sys_clk     (sys_clk),
                .rst         (rst),
                .pin_async   (line_in[g]),
                .pix_tick    (s_reg.pix_tick),
                .us_tick     (s_reg.us_tick),
                .use_us      (use_us[g]),
                .glitch_us   (s_reg.glitch_filter_us[g]),
                .level_sync  (level_sync[g]),
                .level_clean (level_clean[g])
            );
        end
    endgenerate

    function automatic logic [LINES-1:0] pin_levels(input state_t s,
                                                   input logic [LINES-1:0] in);
        logic [LINES-1:0] lv;
        lv = '0;
        for (int i = 0; i < LINES; i++) begin
            lv[i] = s.oe[i] ? s.out[i] : in[i];
        end
        return lv;
    endfunction

    function automatic logic us_done(input state_t s, input logic [15:0] tgt);
        logic d;
        d = (tgt == 16'h0000) || (s.us_tick && (s.st_cnt + 16'h0001 >= tgt));
        return d;
    endfunction

    always_comb begin
        logic             window;
        logic             start;
        logic [LINES-1:0] lv;
        logic [LINES-1:0] inv_in;
        logic             edge_seen;
        logic             src;
        logic [3:0]       allowed;
        line_cfg_t        wcfg;
        window    = 1'b0;
        start     = 1'b0;
        lv        = pin_levels(s_reg, level_sync);
        inv_in    = '0;
        edge_seen = 1'b0;
        src       = 1'b0;
        allowed   = 4'h0;
        wcfg      = line_cfg_t'(pwdata[`GP_LINE_W-1:0]);
        s_next    = s_reg;

        // pixel and microsecond enables from one divider each
        s_next.pix_tick = (s_reg.pix_cnt == PIX_LAST);
        s_next.pix_cnt  = s_next.pix_tick ? 8'h00 : s_reg.pix_cnt + 8'h01;
        s_next.us_tick  = (s_reg.us_cnt == US_LAST);
        s_next.us_cnt   = s_next.us_tick ? 8'h00 : s_reg.us_cnt + 8'h01;

        unique case (s_reg.exposure_window_kind)
            `GP_WIN_ANY: window = exposure_any;
            `GP_WIN_ALL: window = exposure_all;
            default:     window = exposure_line1;
        endcase
        s_next.win_prev = window;

        // trigger lines grab on an edge
        for (int i = 0; i < LINES; i++) begin
            inv_in[i] = level_clean[i] ^ s_reg.cfg[i].polarity_flip;
            if ((s_reg.cfg[i].line_function == FN_INPUT ||
                 s_reg.cfg[i].line_function == FN_TRIGGER) &&
                inv_in[i] && !s_reg.prev_in[i]) begin
                edge_seen = 1'b1;
            end
        end
        s_next.prev_in = inv_in;
        s_next.grab    = s_reg.trig_mode && edge_seen;
        // a new trigger wins over the clearing window edge
        if (s_reg.grab) begin
            s_next.trig_active = 1'b1;
        end else if (s_reg.win_prev && !window) begin
            s_next.trig_active = 1'b0;
        end

        // strobe start from integration or trigger
        start = s_reg.from_trig ? s_reg.grab : integration_start;
        unique case (s_reg.st)
            ST_IDLE: begin
                if (start) begin
                    for (int i = 0; i < LINES; i++) begin
                        s_next.fire_mask[i] = s_reg.cfg[i].flash_pulse_on &&
                            s_reg.pattern[i][s_reg.frame_idx];
                    end
                    s_next.frame_idx   = s_reg.frame_idx + 3'h1;
                    s_next.pulses_left = s_reg.flash_pulse_length;
                    s_next.st_cnt      = 16'h0000;
                    s_next.st          = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (s_reg.us_tick) begin
                    s_next.st_cnt = s_reg.st_cnt + 16'h0001;
                end
                if (us_done(s_reg, s_reg.delay_us)) begin
                    s_next.st_cnt = 16'h0000;
                    s_next.st = (s_reg.pulses_left == 8'h00) ? ST_EXPO
                                                              : ST_HIGH;
                end
            end
            ST_HIGH: begin
                s_next.strobe_level = 1'b1;
                if (s_reg.us_tick) begin
                    s_next.st_cnt = s_reg.st_cnt + 16'h0001;
                end
                if (s_reg.strobe_level && us_done(s_reg, s_reg.high_us)) begin
                    s_next.strobe_level = 1'b0;
                    s_next.st_cnt       = 16'h0000;
                    s_next.pulses_left  = s_reg.pulses_left - 8'h01;
                    s_next.st           = ST_LOW;
                end
            end
            ST_LOW: begin
                if (s_reg.us_tick) begin
                    s_next.st_cnt = s_reg.st_cnt + 16'h0001;
                end
                if (us_done(s_reg, s_reg.low_us)) begin
                    s_next.st_cnt = 16'h0000;
                    s_next.st = (s_reg.pulses_left == 8'h00) ? ST_IDLE
                                                              : ST_HIGH;
                end
            end
            ST_EXPO: begin
                // st_cnt bit 0 marks that the window has opened
                s_next.strobe_level = window;
                if (window) begin
                    s_next.st_cnt = 16'h0001;
                end else if (s_reg.st_cnt[0]) begin
                    s_next.st = ST_IDLE;
                end
            end
        endcase

        // per-line pin drive
        for (int i = 0; i < LINES; i++) begin
            unique case (s_reg.cfg[i].output_signal_choice)
                SRC_EXPOSURE: src = window;
                SRC_TRIGGER:  src = s_reg.trig_active;
                default:      src = s_reg.cfg[i].software_drive_level;
            endcase
            unique case (s_reg.cfg[i].line_function)
                FN_OUTPUT: begin
                    s_next.out[i] = src ^ s_reg.cfg[i].polarity_flip;
                    s_next.oe[i]  = 1'b1;
                end
                FN_STROBE: begin
                    s_next.out[i] = (s_reg.strobe_level &&
                        s_reg.fire_mask[i]) ^ s_reg.cfg[i].polarity_flip;
                    s_next.oe[i]  = 1'b1;
                end
                default: begin
                    s_next.out[i] = 1'b0;
                    s_next.oe[i]  = 1'b0;
                end
            endcase
        end

        // apb: one wait state, commit at the edge that sees pready
        s_next.ready = 1'b0;
        s_next.err   = 1'b0;
        if (psel && penable && s_reg.ready) begin
            if (pwrite && !s_reg.err) begin
                unique case (paddr)
                    `GP_OFS_PICK: s_next.line_pick = pwdata[1:0];
                    `GP_OFS_LINE: begin
                        // disallowed functions keep the old one
                        allowed = FN_ALLOWED[s_reg.line_pick*4 +: 4];
                        if (!allowed[wcfg.line_function]) begin
                            wcfg.line_function =
                                s_reg.cfg[s_reg.line_pick].line_function;
                        end
                        s_next.cfg[s_reg.line_pick] = wcfg;
                    end
                    `GP_OFS_GLITCH:
                        s_next.glitch_filter_us[s_reg.line_pick] =
                            pwdata[15:0];
                    `GP_OFS_PULSE_CNT: s_next.flash_pulse_length = pwdata[7:0];
                    `GP_OFS_HIGH:  s_next.high_us  = pwdata[15:0];
                    `GP_OFS_LOW:   s_next.low_us   = pwdata[15:0];
                    `GP_OFS_DELAY: s_next.delay_us = pwdata[15:0];
                    `GP_OFS_PATTERN:
                        s_next.pattern[s_reg.line_pick] = pwdata[7:0];
                    `GP_OFS_GLOBAL: begin
                        s_next.aux       = pwdata[`GP_GLB_AUX];
                        s_next.trig_mode = pwdata[`GP_GLB_TRIG];
                        s_next.from_trig = pwdata[`GP_GLB_FROM_TRIG];
                        s_next.exposure_window_kind =
                            pwdata[`GP_GLB_WIN_MSB:`GP_GLB_WIN_LSB];
                    end
                    default: ;
                endcase
            end
        end else if (psel && penable) begin
            s_next.ready = 1'b1;
            s_next.rdata = 32'h0000_0000;
            unique case (paddr)
                `GP_OFS_PICK: s_next.rdata[1:0] = s_reg.line_pick;
                `GP_OFS_LINE: s_next.rdata[`GP_LINE_W-1:0] =
                    s_reg.cfg[s_reg.line_pick];
                `GP_OFS_GLITCH: s_next.rdata[15:0] =
                    s_reg.glitch_filter_us[s_reg.line_pick];
                `GP_OFS_PULSE_CNT: s_next.rdata[7:0] = s_reg.flash_pulse_length;
                `GP_OFS_HIGH:  s_next.rdata[15:0] = s_reg.high_us;
                `GP_OFS_LOW:   s_next.rdata[15:0] = s_reg.low_us;
                `GP_OFS_DELAY: s_next.rdata[15:0] = s_reg.delay_us;
                `GP_OFS_PATTERN: s_next.rdata[7:0] =
                    s_reg.pattern[s_reg.line_pick];
                `GP_OFS_LEVEL: s_next.rdata[0] = lv[s_reg.line_pick];
                `GP_OFS_ALL: s_next.rdata[LINES-1:0] = lv;
                `GP_OFS_GLOBAL: begin
                    s_next.rdata[`GP_GLB_AUX]       = s_reg.aux;
                    s_next.rdata[`GP_GLB_TRIG]      = s_reg.trig_mode;
                    s_next.rdata[`GP_GLB_FROM_TRIG] = s_reg.from_trig;
                    s_next.rdata[`GP_GLB_WIN_MSB:`GP_GLB_WIN_LSB] =
                        s_reg.exposure_window_kind;
                end
                default: s_next.err = 1'b1;
            endcase
        end
    end

    // reset gives every line its legal default function
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_reg    <= '0;
            s_reg.st <= ST_IDLE;
            for (int i = 0; i < LINES; i++) begin
                s_reg.cfg[i].line_function <= line_fn_t'(RST_FN[i*2 +: 2]);
                s_reg.pattern[i]           <= `GP_RST_PATTERN;
            end
        end else begin
            s_reg <= s_next;
        end
    end

    assign prdata         = s_reg.rdata;
    assign pready         = s_reg.ready;
    assign pslverr        = s_reg.err;
    assign line_out       = s_reg.out;
    assign line_oe        = s_reg.oe;
    assign grab_trigger   = s_reg.grab;
    assign stream_suspend = s_reg.trig_mode;
    assign aux_supply_on  = s_reg.aux;

endmodule

`default_nettype wire

// File: verification/gpio_line_checker.sv
`timescale 1ns/10ps
`default_nettype none
module gpio_line_checker #(
    parameter int LINES   = 4,
    parameter int PIX_DIV = 4
) (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        grab_trigger,
    input wire logic        stream_suspend,
    input wire logic        aux_supply_on
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // commit of a write to the global word
    logic wr_glb;
    assign wr_glb = psel && penable && pready && pwrite && paddr == 8'h28;
    property p_susp; $rose(stream_suspend) |->
        $past(wr_glb) && $past(pwdata[1]);
    endproperty
    a_susp: assert property (p_susp)
        else $error("suspend rose without a write");
    property p_aux; $changed(aux_supply_on) |->
        $past(wr_glb) && aux_supply_on == $past(pwdata[0]); endproperty
    a_aux: assert property (p_aux)
        else $error("aux supply moved without a write");
    property p_grab; grab_trigger |-> stream_suspend || $past(stream_suspend);
    endproperty
    a_grab: assert property (p_grab)
        else $error("grab outside trigger mode");
    property p_one; grab_trigger |=> !grab_trigger [*8]; endproperty
    a_one: assert property (p_one)
        else $error("grab repeated too soon");
    property p_wait; psel && $rose(penable) |-> !pready ##1 pready; endproperty
    a_wait: assert property (p_wait)
        else $error("ready not after one wait cycle");
    property p_src; pready |-> psel && penable; endproperty
    a_src: assert property (p_src)
        else $error("ready outside an access");
    property p_err; pready && paddr > 8'h28 |-> pslverr && prdata == 32'h0;
    endproperty
    a_err: assert property (p_err)
        else $error("unmapped access not refused");
    property p_all; pready && !pwrite && paddr == 8'h24 |->
        (prdata >> LINES) == 32'h0; endproperty
    a_all: assert property (p_all)
        else $error("level bitfield wider than the lines");
endmodule
`default_nettype wire

// File: verification/line_partner.sv
`timescale 1ns/10ps
`default_nettype none
module line_partner (
    input  wire logic       sys_clk,
    input  wire logic [3:0] line_out,
    input  wire logic [3:0] line_oe,
    output logic      [3:0] line_in
);
    logic [3:0] drv = 4'h0;
    logic       last = 1'b0;
    int         rises = 0;
    // device wins where it drives, else the far side level
    assign line_in = (line_oe & line_out) | (~line_oe & drv);
    task automatic pulse(input int l, input int w);
        @(posedge sys_clk);
        drv[l] <= 1'b1;
        repeat (w) @(posedge sys_clk);
        drv[l] <= 1'b0;
    endtask
    task automatic set(input int l, input logic v);
        @(posedge sys_clk);
        drv[l] <= v;
    endtask
    // flash equipment counts strobe pulses on line 3
    always @(posedge sys_clk) begin
        last <= line_oe[3] & line_out[3];
        if (line_oe[3] && line_out[3] && !last) rises <= rises + 1;
    end
endmodule
`default_nettype wire

// File: verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "gpio_line_defs.svh"
module testbench;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err, grab, susp, aux;
    logic        istart = 1'b0;
    logic [2:0]  expo = 3'h0;
    logic [3:0]  lin, lout, loe;
    logic [31:0] seed = 32'h6d39;
    logic [1:0]  cur [4] = '{2'h0, 2'h1, 2'h0, 2'h0};
    int          bad_count = 0;
    int          checked = 0;
    int          cyc = 0;
    int          grabs = 0;
    always #2.5 sys_clk = ~sys_clk;
    camera_gpio_line_control dut (
        .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .line_in(lin), .line_out(lout),
        .line_oe(loe), .integration_start(istart), .exposure_line1(expo[0]),
        .exposure_any(expo[1]), .exposure_all(expo[2]), .grab_trigger(grab),
        .stream_suspend(susp), .aux_supply_on(aux));
    line_partner far (.sys_clk(sys_clk), .line_out(lout), .line_oe(loe),
        .line_in(lin));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // function codes each line accepts
    function automatic logic ok_fn(input int l, input int f);
        return 1'(`GP_FN_ALLOWED >> (l * 4 + f));
    endfunction
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    // one apb transfer, held until ready is sampled
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cfg(input int l, input logic [31:0] v);
        bus(1'b1, 8'h00, 32'(l));
        bus(1'b1, 8'h04, v);
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge sys_clk);
    endtask
    task automatic kick(input logic [2:0] e);
        expo <= e;
        istart <= 1'b1;
        @(posedge sys_clk);
        istart <= 1'b0;
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // grab counter and hang guard
    always @(posedge sys_clk) begin
        grabs <= grabs + int'(grab);
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            bad_count++;
            finish_test();
        end
    end
    initial begin
        int l, f, g, r;
        wt(6);
        rst <= 1'b0;
        wt(3);
        chk("oe", 32'h2, 32'(loe));
        bus(1'b0, 8'h04, 32'h0); chk("fn0", 32'h0, rd);
        bus(1'b0, 8'h1c, 32'h0); chk("pattern", 32'hff, rd);
        bus(1'b0, 8'h28, 32'h0); chk("global", 32'h0, rd);
        bus(1'b0, 8'h30, 32'h0); chk("unmapped", 32'h1, 32'(err));
        // random function codes, refused ones keep the old code
        for (int i = 0; i < 12; i++) begin
            l = int'(rnd() % 4);
            f = int'(rnd() % 4);
            if (ok_fn(l, f)) cur[l] = 2'(f);
            cfg(l, 32'(f));
            bus(1'b0, 8'h04, 32'h0);
            chk("fn", 32'(cur[l]), rd);
        end
        cfg(0, 32'h0);
        cfg(3, 32'h0);
        cfg(2, 32'h49);
        wt(4); chk("user", 32'h3, 32'({loe[2], lout[2]}));
        cfg(2, 32'h59);
        far.set(3, 1'b1);
        wt(6); chk("flip", 32'h2, 32'({loe[2], lout[2]}));
        bus(1'b0, 8'h20, 32'h0); chk("level", 32'h0, rd);
        bus(1'b0, 8'h24, 32'h0); chk("all", 32'h8, rd);
        far.set(3, 1'b0);
        wt(80);
        bus(1'b1, 8'h28, 32'h3);
        wt(2); chk("susp", 32'h3, 32'({susp, aux}));
        cfg(1, 32'h5);
        g = grabs;
        far.pulse(0, 40);
        wt(100); chk("short", 32'(g), 32'(grabs));
        far.pulse(0, 100);
        wt(20); chk("long", 32'(g + 1), 32'(grabs));
        chk("trig_act", 32'h1, 32'(lout[1]));
        kick(3'h1);
        wt(4);
        expo <= 3'h0;
        wt(4); chk("trig_clr", 32'h0, 32'(lout[1]));
        bus(1'b1, 8'h00, 32'h0);
        bus(1'b1, 8'h08, 32'h2);
        far.pulse(0, 100);
        wt(500); chk("glitch", 32'(g + 1), 32'(grabs));
        far.pulse(0, 600);
        wt(600); chk("debounced", 32'(g + 2), 32'(grabs));
        cfg(0, 32'h2);
        far.pulse(0, 100);
        wt(20); chk("trigfn", 32'(g + 3), 32'(grabs));
        cfg(3, 32'h23);
        // every exposure window kind, count zero follows the window
        for (int k = 0; k < 3; k++) begin
            bus(1'b1, 8'h28, 32'(k) << 3);
            kick(3'(1 << k));
            wt(4); chk("win", 32'h3, 32'({loe[3], lout[3]}));
            expo <= 3'h0;
            wt(4); chk("win_end", 32'h0, 32'(lout[3]));
        end
        bus(1'b1, 8'h0c, 32'h2);
        bus(1'b1, 8'h10, 32'h1);
        bus(1'b1, 8'h14, 32'h1);
        r = far.rises;
        kick(3'h0);
        wt(1200); chk("pulses", 32'(r + 2), 32'(far.rises));
        bus(1'b1, 8'h1c, 32'h0);
        kick(3'h0);
        wt(1200); chk("masked", 32'(r + 2), 32'(far.rises));
        finish_test();
    end
endmodule
bind camera_gpio_line_control gpio_line_checker #(.LINES(LINES),
    .PIX_DIV(PIX_DIV)) chk_i (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .grab_trigger(grab_trigger), .stream_suspend(stream_suspend),
    .aux_supply_on(aux_supply_on));
`default_nettype wire
